// ### hdl/uvob_bank.sv
// output result register bank of the three channel uv sensor
// What this block does
// R1 - all result words 16 bits, measurement only
// R2 - offset zero: writable state byte, then status
// R3 - offset 1 temperature, top nibble zero
// R4 - offsets 2..4 carry channels a, b, c
// R5 - 24-bit time split over offsets 5, 6
// R6 - low byte sent before high byte
// R7 - bit 7 time counter wrap, counter restarts
// R8 - wrap only in edge sync with timing
// R9 - bit 6 result saturated at ffff
// R10 - saturation needs time setting 7 to 15
// R11 - bit 5 converter overdrive during measurement
// R12 - flags follow results held in bank
// R13 - bit 4 lost data, status read clears
// R14 - bit 3 fresh data moved to bank
// R15 - fresh cleared by status or result read
// R16 - bit 2 inverse of ready pin
// R17 - bits 1,0 live standby and powerdown
// R18 - read start copies buffer into bank
// R19 - no refresh during read until stop
// R20 - resets and config return clear bank
// R21 - measurement state selects bank or config
`default_nettype none
`include "uvob_cfg.svh"
module uvob_bank (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // device state
  input  wire logic        meas_state,       // measurement state active
  input  wire logic        soft_reset,       // software reset pulse
  input  wire logic        edge_synced_mode, // externally edge synced mode
  input  wire logic        time_measure_enable,
  input  wire logic [3:0]  time_setting,     // conversion time code
  input  wire logic        ready_pin_level,  // level driven on ready pin
  input  wire logic        standby_ctl,      // live internal standby
  input  wire logic        powerdown_ctl,    // live internal power down
  // measurement engine
  input  wire logic        conv_tick,        // time counter advance
  input  wire logic        conv_start,       // conversion begins
  input  wire logic        conv_done,        // conversion ends, values valid
  input  wire logic [15:0] temp_value,
  input  wire logic [15:0] cha_count,
  input  wire logic [15:0] chb_count,
  input  wire logic [15:0] chc_count,
  input  wire logic [2:0]  cha_ovf,          // channel counter passed ffff
  input  wire logic        adc_overdrive,    // analog overdrive seen
  // serial read side
  input  wire logic        rd_start,         // serial read operation begins
  input  wire logic        rd_stop,          // stop condition received
  input  wire logic        byte_req,         // next read byte wanted
  input  wire logic [3:0]  rd_addr,          // register index of the read
  input  wire logic        wr_state,         // write of state byte
  input  wire logic [7:0]  wr_byte,
  input  wire logic [7:0]  cfg_rd_byte,      // config register byte
  // outputs
  output logic [7:0]       rd_byte,          // byte for serial shifter
  output logic             rd_byte_valid,
  output logic [7:0]       operating_state_reg,
  output logic [7:0]       measurement_flags
);
  // carrier to the snapshot store, which holds the readable words
  uvob_snap_if sp ();

  // snapshot store instance
  uvob_store u_store (
    .clk    (clk),
    .resetn (resetn),
    .sp     (sp)
  );

  // state registers
  uvob_pkg::uvob_snap_t   buf_reg, buf_next;   // end of conversion buffer
  logic [23:0]            tcnt_reg, tcnt_next; // conversion time counter
  logic                   wrap_reg, wrap_next; // wrap seen this conversion
  logic                   buf_new_reg, buf_new_next; // buffer not yet moved
  logic                   lost_reg, lost_next;
  logic                   fresh_reg, fresh_next;
  logic                   rd_act_reg, rd_act_next;   // read open until stop
  uvob_pkg::uvob_rd_state_t st_reg, st_next;
  logic [3:0]             idx_reg, idx_next;   // current read index
  logic [7:0]             hi_reg, hi_next;     // second byte of word
  logic [7:0]             byte_reg, byte_next;
  logic                   bval_reg, bval_next;
  logic [7:0]             osr_reg, osr_next;
  logic [7:0]             flags_reg, flags_next;
  logic                   clr_all;             // bank wide clear
  logic                   sat_allowed;
  logic [2:0]             sat_vec;             // per channel saturation
  logic [15:0]            ch_sat [3];
  logic [15:0]            cur_word;            // word at read index
  uvob_pkg::uvob_snap_t   bank;

  // any clear source empties buffer, bank and event flags alike
  assign clr_all     = soft_reset | ~meas_state; // R20
  assign sat_allowed = (time_setting >= `UVOB_SAT_TIME_MIN); // R10
  assign bank        = sp.rd_data;

  // saturate each channel rather than wrap
  // limitation: overflow only saturates for long time settings
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sat
      logic [15:0] raw;
      assign raw = (gi == 0) ? cha_count : ((gi == 1) ? chb_count : chc_count);
      assign sat_vec[gi] = cha_ovf[gi] & sat_allowed;
      assign ch_sat[gi]  = sat_vec[gi] ? `UVOB_RES_MAX : raw; // R9
    end
  endgenerate

  // time counter, buffer and event flags
  always_comb begin
    tcnt_next    = tcnt_reg;
    wrap_next    = wrap_reg;
    buf_next     = buf_reg;
    buf_new_next = buf_new_reg;
    lost_next    = lost_reg;
    fresh_next   = fresh_reg;
    rd_act_next  = rd_act_reg;
    if (conv_start) begin
      tcnt_next = 24'h000000;
      wrap_next = 1'b0;
    end else if (conv_tick && edge_synced_mode && time_measure_enable) begin
      // 24-bit counter wraps and keeps counting
      tcnt_next = tcnt_reg + 24'h000001; // R7
      if (tcnt_reg == 24'hffffff) begin
        wrap_next = 1'b1; // R8
      end
    end
    // clears first so that sets below win
    if (byte_req && !rd_start && st_reg == uvob_pkg::UVOB_IDLE && meas_state) begin
      if (idx_reg == `UVOB_ADDR_STATE) begin
        lost_next  = 1'b0; // R13
        fresh_next = 1'b0; // R15
      end else if (idx_reg <= `UVOB_ADDR_LAST) begin
        fresh_next = 1'b0; // R15
      end
    end
    // stop closes the read, the bank may refresh again
    if (rd_stop) begin
      rd_act_next = 1'b0;
    end
    // end of conversion lands in the buffer, never straight in the bank
    if (conv_done) begin
      buf_next.temp = temp_value & `UVOB_TEMP_MASK; // R3
      buf_next.cha  = ch_sat[0]; // R4
      buf_next.chb  = ch_sat[1];
      buf_next.chc  = ch_sat[2];
      buf_next.conv = tcnt_reg; // R5
      buf_next.wrap = wrap_reg; // R12
      buf_next.sat  = |sat_vec;
      buf_next.ovd  = adc_overdrive; // R11
      buf_new_next  = 1'b1;
      if (buf_new_reg) begin
        lost_next = 1'b1; // R13
      end
    end
    // a copy deferred by a same cycle capture waits for the next read
    if (rd_start && !rd_act_reg) begin
      rd_act_next = 1'b1;
      if (buf_new_reg && !conv_done) begin
        buf_new_next = 1'b0;
        fresh_next   = 1'b1; // R14
      end
    end
    // clear last so it beats every set above
    if (clr_all) begin
      buf_next     = '0;
      buf_new_next = 1'b0;
      lost_next    = 1'b0;
      fresh_next   = 1'b0;
      wrap_next    = 1'b0;
      tcnt_next    = 24'h000000;
      rd_act_next  = 1'b0;
    end
  end

  // move buffer to bank only at read start, never inside a read
  assign sp.wr_en   = rd_start && !rd_act_reg && buf_new_reg && !conv_done; // R18 R19
  assign sp.wr_data = buf_reg;
  assign sp.clr     = clr_all; // R20

  // pick the 16-bit word at the current index
  always_comb begin
    cur_word = `UVOB_WORD_RESET;
    case (idx_reg)
      `UVOB_ADDR_STATE: cur_word = {flags_reg, osr_reg}; // R2
      `UVOB_ADDR_TEMP:  cur_word = bank.temp; // R3
      `UVOB_ADDR_CHA:   cur_word = bank.cha; // R4
      `UVOB_ADDR_CHB:   cur_word = bank.chb;
      `UVOB_ADDR_CHC:   cur_word = bank.chc;
      `UVOB_ADDR_CONVL: cur_word = bank.conv[15:0]; // R5
      `UVOB_ADDR_CONVH: cur_word = {8'h00, bank.conv[23:16]};
      default:          cur_word = `UVOB_WORD_RESET;
    endcase
  end

  // byte readout sequencer
  always_comb begin
    st_next   = st_reg;
    idx_next  = idx_reg;
    hi_next   = hi_reg;
    byte_next = byte_reg;
    bval_next = 1'b0;
    // a new read start refuses any byte request in the same cycle
    if (rd_start) begin
      idx_next = rd_addr;
      st_next  = uvob_pkg::UVOB_IDLE;
    end else if (byte_req) begin
      bval_next = 1'b1;
      case (st_reg)
        uvob_pkg::UVOB_IDLE: begin
          if (!meas_state) begin
            byte_next = cfg_rd_byte; // R21
            idx_next  = idx_reg + 4'h1;
          end else if (idx_reg > `UVOB_ADDR_LAST) begin
            // indices past the bank read as zero yet still advance
            byte_next = 8'h00; // R1
            idx_next  = idx_reg + 4'h1;
          end else begin
            byte_next = cur_word[7:0]; // R6
            hi_next   = cur_word[15:8];
            st_next   = uvob_pkg::UVOB_HIGH;
          end
        end
        // second byte of the word, then step to the next index
        uvob_pkg::UVOB_HIGH: begin
          byte_next = hi_reg; // R6
          idx_next  = idx_reg + 4'h1;
          st_next   = uvob_pkg::UVOB_IDLE;
        end
        default: st_next = uvob_pkg::UVOB_IDLE;
      endcase
    end
  end

  // state byte and live status
  always_comb begin
    osr_next = osr_reg;
    if (wr_state) begin
      osr_next = wr_byte; // R2
    end
    // lost and fresh bits use next flag values so their clear is never one cycle late
    flags_next = 8'h00;
    flags_next[`UVOB_BIT_WRAP]  = bank.wrap; // R7 R12
    flags_next[`UVOB_BIT_SAT]   = bank.sat;  // R9 R12
    flags_next[`UVOB_BIT_OVD]   = bank.ovd;  // R11 R12
    flags_next[`UVOB_BIT_LOST]  = lost_next; // R13
    flags_next[`UVOB_BIT_FRESH] = fresh_next; // R14
    flags_next[`UVOB_BIT_BUSY]  = ~ready_pin_level; // R16
    flags_next[`UVOB_BIT_STBY]  = standby_ctl; // R17
    flags_next[`UVOB_BIT_PDN]   = powerdown_ctl; // R17
  end

  // register all state
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      buf_reg     <= '0;
      tcnt_reg    <= 24'h000000;
      wrap_reg    <= 1'b0;
      buf_new_reg <= 1'b0;
      lost_reg    <= 1'b0;
      fresh_reg   <= 1'b0;
      rd_act_reg  <= 1'b0;
      st_reg      <= uvob_pkg::UVOB_IDLE;
      idx_reg     <= 4'h0;
      hi_reg      <= 8'h00;
      byte_reg    <= 8'h00;
      bval_reg    <= 1'b0;
      osr_reg     <= `UVOB_OSR_RESET;
      flags_reg   <= 8'h00;
    end else begin
      buf_reg     <= buf_next;
      tcnt_reg    <= tcnt_next;
      wrap_reg    <= wrap_next;
      buf_new_reg <= buf_new_next;
      lost_reg    <= lost_next;
      fresh_reg   <= fresh_next;
      rd_act_reg  <= rd_act_next;
      st_reg      <= st_next;
      idx_reg     <= idx_next;
      hi_reg      <= hi_next;
      byte_reg    <= byte_next;
      bval_reg    <= bval_next;
      osr_reg     <= osr_next;
      flags_reg   <= flags_next;
    end
  end

  // every output comes straight from a flip-flop
  assign rd_byte             = byte_reg;
  assign rd_byte_valid       = bval_reg;
  assign operating_state_reg = osr_reg;
  assign measurement_flags   = flags_reg;

  // checks next to the logic
  a_bank_clear: assert property (@(posedge clk) disable iff (!resetn) // R20
    !meas_state |=> (bank == '0)) else $error("bank not cleared");
  a_busy_inv: assert property (@(posedge clk) disable iff (!resetn) // R16
    resetn |=> measurement_flags[2] == !$past(ready_pin_level))
    else $error("busy flag wrong");
  a_lost_set: assert property (@(posedge clk) disable iff (!resetn) // R13
    conv_done && buf_new_reg && meas_state && !soft_reset |=> lost_reg)
    else $error("lost not set");
  a_no_refresh: assert property (@(posedge clk) disable iff (!resetn) // R19
    rd_act_reg && !rd_stop && meas_state && !soft_reset |=> $stable(bank))
    else $error("bank changed in read");
  a_copy_start: assert property (@(posedge clk) disable iff (!resetn) // R18
    sp.wr_en && !clr_all |=> bank == $past(buf_reg) && fresh_reg)
    else $error("copy missing");
  a_temp_top: assert property (@(posedge clk) disable iff (!resetn) // R3
    bank.temp[15:12] == 4'h0) else $error("temp top nibble set");
  a_low_first: assert property (@(posedge clk) disable iff (!resetn) // R6
    byte_req && !rd_start && meas_state && st_reg == uvob_pkg::UVOB_IDLE
    && idx_reg == `UVOB_ADDR_CHA |=> rd_byte == $past(bank.cha[7:0]))
    else $error("low byte not first");
  a_wrap_mode: assert property (@(posedge clk) disable iff (!resetn) // R8
    !edge_synced_mode && !conv_start && !clr_all |=> wrap_reg == $past(wrap_reg))
    else $error("wrap outside mode");
  // counter, saturation, live bit and readout checks
  a_tcnt_step: assert property (@(posedge clk) disable iff (!resetn) // R7
    conv_tick && edge_synced_mode && time_measure_enable && !conv_start && !clr_all
    |=> tcnt_reg == $past(tcnt_reg) + 24'h000001) else $error("time counter step wrong");
  a_sat_hold: assert property (@(posedge clk) disable iff (!resetn) // R9
    conv_done && !clr_all && cha_ovf[1] && time_setting >= `UVOB_SAT_TIME_MIN
    |=> buf_reg.chb == `UVOB_RES_MAX && buf_reg.sat) else $error("saturation missing");
  a_sat_short: assert property (@(posedge clk) disable iff (!resetn) // R10
    conv_done && !clr_all && time_setting < `UVOB_SAT_TIME_MIN |=> !buf_reg.sat)
    else $error("saturation on short time");
  a_fresh_clear: assert property (@(posedge clk) disable iff (!resetn) // R15
    byte_req && !rd_start && meas_state && st_reg == uvob_pkg::UVOB_IDLE
    && idx_reg <= `UVOB_ADDR_LAST |=> !fresh_reg) else $error("fresh not cleared");
  a_live_bits: assert property (@(posedge clk) disable iff (!resetn) // R17
    resetn |=> measurement_flags[1:0] == $past({standby_ctl, powerdown_ctl}))
    else $error("live state bits wrong");
  a_conv_top: assert property (@(posedge clk) disable iff (!resetn) // R5
    byte_req && !rd_start && meas_state && st_reg == uvob_pkg::UVOB_IDLE
    && idx_reg == `UVOB_ADDR_CONVH |=> hi_reg == 8'h00) else $error("time top byte not zero");
  a_cfg_byte: assert property (@(posedge clk) disable iff (!resetn) // R21
    byte_req && !rd_start && !meas_state |=> rd_byte == $past(cfg_rd_byte))
    else $error("config byte not served");
endmodule
`default_nettype wire

// ### hdl/uvob_cfg.svh
// constants of the uv sensor output result bank
`ifndef UVOB_CFG_SVH
`define UVOB_CFG_SVH
`define UVOB_ADDR_STATE      4'h0
`define UVOB_ADDR_TEMP       4'h1
`define UVOB_ADDR_CHA        4'h2
`define UVOB_ADDR_CHB        4'h3
`define UVOB_ADDR_CHC        4'h4
`define UVOB_ADDR_CONVL      4'h5
`define UVOB_ADDR_CONVH      4'h6
`define UVOB_ADDR_LAST       4'h6
`define UVOB_BIT_WRAP        7
`define UVOB_BIT_SAT         6
`define UVOB_BIT_OVD         5
`define UVOB_BIT_LOST        4
`define UVOB_BIT_FRESH       3
`define UVOB_BIT_BUSY        2
`define UVOB_BIT_STBY        1
`define UVOB_BIT_PDN         0
`define UVOB_RES_MAX         16'hffff
`define UVOB_TEMP_MASK       16'h0fff
`define UVOB_OSR_RESET       8'h02
`define UVOB_WORD_RESET      16'h0000
`define UVOB_SAT_TIME_MIN    4'h7
`endif

// ### hdl/uvob_pkg.sv
// types shared by the output bank files
`default_nettype none
package uvob_pkg;
  // readout sequencer states
  typedef enum logic [1:0] {
    UVOB_IDLE,
    UVOB_LOW,
    UVOB_HIGH
  } uvob_rd_state_t;
  // one snapshot of all measurement values
  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] cha;
    logic [15:0] chb;
    logic [15:0] chc;
    logic [23:0] conv;
    logic        wrap;
    logic        sat;
    logic        ovd;
  } uvob_snap_t;
endpackage
`default_nettype wire

// ### hdl/uvob_if.sv
// carrier between bank top and its snapshot store
`default_nettype none
interface uvob_snap_if;
  logic                 wr_en;   // store new snapshot
  uvob_pkg::uvob_snap_t wr_data; // snapshot to store
  logic                 clr;     // clear whole store
  uvob_pkg::uvob_snap_t rd_data; // registered snapshot
  modport owner (output wr_en, output wr_data, output clr, input rd_data);
  modport store (input wr_en, input wr_data, input clr, output rd_data);
endinterface
`default_nettype wire

// ### hdl/uvob_store.sv
// result register store with registered read data
`default_nettype none
`include "uvob_cfg.svh"
module uvob_store (
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // snapshot port
  uvob_snap_if.store sp
);
  uvob_pkg::uvob_snap_t mem_reg;  // held result words
  uvob_pkg::uvob_snap_t mem_next; // next content

  // clear beats load, so a config return always empties the bank
  always_comb begin
    mem_next = mem_reg;
    if (sp.clr) begin
      mem_next = '0; // R20
    end else if (sp.wr_en) begin
      mem_next = sp.wr_data;
    end
  end

  // register the store
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_reg <= '0; // R20
    end else begin
      mem_reg <= mem_next;
    end
  end

  assign sp.rd_data = mem_reg;
endmodule
`default_nettype wire

// ### testbench/uvob_host_model.sv
// host model that issues serial reads of the output bank
`default_nettype none
module uvob_host_model (
  // clock
  input  wire logic       clk,
  // read requests towards the bank
  output var logic        rd_start,
  output var logic        rd_stop,
  output var logic        byte_req,
  output var logic [3:0]  rd_addr,
  // bytes coming back
  input  wire logic [7:0] rd_byte,
  input  wire logic       rd_byte_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle levels, nothing requested before reset ends
  initial begin
    rd_start = 1'b0;
    rd_stop  = 1'b0;
    byte_req = 1'b0;
    rd_addr  = 4'h0;
  end
  // start condition plus index; index held, the bank latches it
  task automatic begin_read(input logic [3:0] a);
    @(posedge clk);
    rd_start <= 1'b1;
    rd_addr  <= a;
    @(posedge clk);
    rd_start <= 1'b0;
  endtask
  // stop condition closes the read and lets the bank refresh again
  task automatic end_read();
    @(posedge clk);
    rd_stop <= 1'b1;
    @(posedge clk);
    rd_stop <= 1'b0;
  endtask
  // one byte; gap lets the host be slow between bytes
  task automatic get_byte(input int gap, output logic [7:0] b, output logic v);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    byte_req <= 1'b1;
    @(posedge clk);
    byte_req <= 1'b0;
    #1;
    v = rd_byte_valid;
    b = rd_byte;
  endtask
endmodule
`default_nettype wire

// ### testbench/test_uvob_bank.sv
// self checking bench of the output result bank
`default_nettype none
`include "uvob_cfg.svh"
module test_uvob_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, meas_state, soft_reset, edge_synced_mode, time_measure_enable;
  logic [3:0] time_setting;
  logic ready_pin_level, standby_ctl, powerdown_ctl, conv_tick, conv_start, conv_done;
  logic [15:0] temp_value, cha_count, chb_count, chc_count;
  logic [2:0] cha_ovf;
  logic adc_overdrive, rd_start, rd_stop, byte_req, wr_state, rd_byte_valid;
  logic [3:0] rd_addr;
  logic [7:0] wr_byte, cfg_rd_byte, rd_byte, operating_state_reg, measurement_flags;
  int err_total, n_checks, cyc;
  logic [15:0] got[$];         // words of the last read run
  logic [15:0] exp1 [1:7] = '{16'h0bcd, 16'h1234, 16'hffff, 16'h9abc,
                              16'h0003, 16'h0000, 16'h0000};
  // 20 mhz clock
  initial clk = 1'b0;
  always #25 clk = ~clk;
  uvob_bank i_dut (.clk(clk), .resetn(resetn), .meas_state(meas_state),
    .soft_reset(soft_reset), .edge_synced_mode(edge_synced_mode),
    .time_measure_enable(time_measure_enable), .time_setting(time_setting),
    .ready_pin_level(ready_pin_level), .standby_ctl(standby_ctl),
    .powerdown_ctl(powerdown_ctl), .conv_tick(conv_tick), .conv_start(conv_start),
    .conv_done(conv_done), .temp_value(temp_value), .cha_count(cha_count),
    .chb_count(chb_count), .chc_count(chc_count), .cha_ovf(cha_ovf),
    .adc_overdrive(adc_overdrive), .rd_start(rd_start), .rd_stop(rd_stop),
    .byte_req(byte_req), .rd_addr(rd_addr), .wr_state(wr_state), .wr_byte(wr_byte),
    .cfg_rd_byte(cfg_rd_byte), .rd_byte(rd_byte), .rd_byte_valid(rd_byte_valid),
    .operating_state_reg(operating_state_reg), .measurement_flags(measurement_flags));
  uvob_host_model i_host (.clk(clk), .rd_start(rd_start), .rd_stop(rd_stop),
    .byte_req(byte_req), .rd_addr(rd_addr), .rd_byte(rd_byte),
    .rd_byte_valid(rd_byte_valid));
  // single comparison point
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // closing report, reached from the end of tests or the timeout
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard; the tests need well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      print_verdict();
    end
  end
  // one conversion: start, counted ticks, then capture of values
  task automatic run_conv(input logic [15:0] t, a, b, c, input logic [2:0] ovf,
                          input logic ovd, input int ticks);
    @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    repeat (ticks) begin
      conv_tick <= 1'b1;
      @(posedge clk);
      conv_tick <= 1'b0;
      @(posedge clk);
    end
    conv_done <= 1'b1;
    temp_value <= t;
    cha_count <= a;
    chb_count <= b;
    chc_count <= c;
    cha_ovf <= ovf;
    adc_overdrive <= ovd;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask
  // settle flags, which lag their cause by up to two cycles
  task automatic flags_is(input logic [7:0] e);
    repeat (2) @(posedge clk);
    #1;
    check({8'h00, measurement_flags}, {8'h00, e});
  endtask
  // read n words from index a; fx[8] high skips the flag check
  task automatic read_run(input logic [3:0] a, input int n, input logic [8:0] fx);
    logic [7:0] lo, hi;
    logic vl, vh;
    got.delete();
    i_host.begin_read(a);
    if (!fx[8]) flags_is(fx[7:0]);
    for (int i = 0; i < n; i++) begin
      i_host.get_byte(i % 2, lo, vl);
      i_host.get_byte(0, hi, vh);
      check({15'h0000, vl & vh}, 16'h0001);
      got.push_back({hi, lo});
    end
  endtask
  // main sequence
  initial begin
    {meas_state, soft_reset, conv_tick, conv_start, conv_done, wr_state} = 6'h00;
    {edge_synced_mode, time_measure_enable, standby_ctl} = 3'h7;
    {ready_pin_level, powerdown_ctl, adc_overdrive} = 3'h0;
    time_setting = 4'h7;
    {temp_value, cha_count, chb_count, chc_count} = 64'h0;
    cha_ovf = 3'h0;
    wr_byte = 8'h00;
    cfg_rd_byte = 8'hc3;
    err_total = 0;
    n_checks = 0;
    cyc = 0;
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    check({8'h00, operating_state_reg}, {8'h00, `UVOB_OSR_RESET});
    check({8'h00, measurement_flags}, 16'h0000);
    check({8'h00, rd_byte}, 16'h0000);
    @(posedge clk);
    resetn <= 1'b1;
    meas_state <= 1'b1;
    $display("test 1 done");
    // full readout with saturation, overdrive, counted time
    run_conv(16'habcd, 16'h1234, 16'h5678, 16'h9abc, 3'b010, 1'b1, 3);
    read_run(4'h0, 8, {1'b0, 8'h6e});
    check({8'h00, got[0][7:0]}, {8'h00, `UVOB_OSR_RESET});
    check({8'h00, got[0][15:8] & 8'he7}, 16'h0066);
    for (int i = 1; i < 8; i++) check(got[i], exp1[i]);
    $display("test 2 done");
    // new data during an open read must not reach the bank
    edge_synced_mode <= 1'b0;
    time_setting <= 4'h6;
    run_conv(16'h0111, 16'h1111, 16'h2121, 16'h3131, 3'b001, 1'b0, 2);
    read_run(4'h2, 1, {1'b0, 8'h66});
    check(got[0], 16'h1234);
    i_host.end_read();
    $display("test 3 done");
    // live state bits flipped, then overwrite before pickup
    ready_pin_level <= 1'b1;
    standby_ctl <= 1'b0;
    powerdown_ctl <= 1'b1;
    run_conv(16'h0222, 16'h2222, 16'h2323, 16'h2424, 3'b111, 1'b0, 2);
    flags_is(8'h71);
    read_run(4'h2, 5, {1'b0, 8'h19});
    check(got[0], 16'h2222);
    check(got[1], 16'h2323);
    check(got[3], 16'h0000);
    flags_is(8'h11);
    i_host.end_read();
    read_run(4'h0, 1, 9'h100);
    flags_is(8'h01);
    i_host.end_read();
    $display("test 4 done");
    // state byte write, then software reset clears results
    @(posedge clk);
    wr_state <= 1'b1;
    wr_byte <= 8'h5a;
    @(posedge clk);
    wr_state <= 1'b0;
    @(posedge clk);
    #1;
    check({8'h00, operating_state_reg}, 16'h005a);
    read_run(4'h0, 1, 9'h100);
    check({8'h00, got[0][7:0]}, 16'h005a);
    i_host.end_read();
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    read_run(4'h2, 1, {1'b0, 8'h01});
    check(got[0], 16'h0000);
    i_host.end_read();
    $display("test 5 done");
    // configuration state serves config bytes instead of the bank
    @(posedge clk);
    meas_state <= 1'b0;
    read_run(4'h3, 1, 9'h100);
    check(got[0], 16'hc3c3);
    i_host.end_read();
    $display("test 6 done");
    print_verdict();
  end
endmodule
`default_nettype wire
